//--- verilog/scp_pkg.sv
// Constants and types shared by the system clock prescaler and trim block
package scp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the register bus)
    // ------------------------------------------------------------
    localparam logic [3:0] TRIM_OFS = 4'h0;
    localparam logic [3:0] DIVCTL_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int UNLOCK_BIT = 7;
    localparam int RSVD_MSB = 6;
    localparam int RSVD_LSB = 4;
    localparam int DIVSEL_MSB = 3;
    localparam int RANGE_BIT = 7;
    localparam int STAT_UNLOCK_BIT = 8;
    localparam int STAT_CLOCK_OUT_FUSE_BIT = 9;
    localparam int STAT_DIV8_BIT = 10;

    // ------------------------------------------------------------
    // Reset values and division codes
    // ------------------------------------------------------------
    localparam logic [3:0] DIVSEL_DIV1 = 4'h0;
    localparam logic [3:0] DIVSEL_DIV8 = 4'h3;
    localparam logic [3:0] DIVSEL_MAX = 4'h8;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [2:0] UNLOCK_TICKS = 3'h4;
    localparam int INIT_STAGES = 3;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Unlock window state
    typedef enum logic {
        UNL_LOCKED,
        UNL_OPEN
    } scp_unl_t;

endpackage

//--- verilog/scp_prescaler.sv
// System clock prescaler with change unlock, RC trim and clock output pin
`timescale 1ns/10ps
module scp_prescaler #(
    parameter int ADDR_W = 4
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [7:0] FACTORY_TRIM_I,
    input wire logic DEFAULT_DIV8_FUSE_I,
    input wire logic CLOCK_OUT_FUSE_I,
    input wire logic CHIP_RESET_I,
    input wire logic PORT_OUT_I,
    input wire logic PORT_OE_N_I,
    output logic SYS_CLK_EN_O,
    output logic SYS_CLK_O,
    output logic CLOCK_OUT_PIN_O,
    output logic CLOCK_OUT_PIN_OE_N_O,
    output logic TRIM_RANGE_SELECT_O,
    output logic [6:0] TRIM_FINE_TUNE_O
);
    import scp_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W must be at least 4");
    end

    // Factor minus one for a code; reserved codes act as 256
    function automatic logic [7:0] fm1_of(input logic [3:0] code);
        logic [3:0] c;
        c = (code > DIVSEL_MAX) ? DIVSEL_MAX : code;
        fm1_of = 8'(({1'b0, 8'h00} | (9'h001 << c)) - 9'h001);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and power-up default loading
    // ------------------------------------------------------------
    logic [10:0] pin_q1_r;
    logic [10:0] pin_q2_r;
    logic [INIT_STAGES-1:0] init_r;
    logic [7:0] fuse_trim;
    logic fuse_div8;
    logic fuse_clock_out_fuse;
    logic chip_rst;
    logic load_def;

    // Fuses and chip reset come from outside, so two flops first
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_q1_r <= 11'h000;
            pin_q2_r <= 11'h000;
        end else if (CE_I) begin
            pin_q1_r <= {CHIP_RESET_I, CLOCK_OUT_FUSE_I,
                         DEFAULT_DIV8_FUSE_I, FACTORY_TRIM_I};
            pin_q2_r <= pin_q1_r;
        end
    end

    assign fuse_trim = pin_q2_r[7:0];
    assign fuse_div8 = pin_q2_r[8];
    assign fuse_clock_out_fuse = pin_q2_r[9];
    assign chip_rst = pin_q2_r[10];

    // Fuse values are only trusted once the synchroniser has filled
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            init_r <= '0;
        end else if (CE_I) begin
            init_r <= {init_r[INIT_STAGES-2:0], 1'b1};
        end
    end

    assign load_def = !init_r[INIT_STAGES-1] || chip_rst;

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    logic aw_full_r;
    logic w_full_r;
    logic [3:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane0_r;
    logic wr_fire;
    logic wr_trim;
    logic wr_div;
    logic aw_hit;

    assign wr_fire = aw_full_r && w_full_r && !S_AXI_BVALID_O;
    assign wr_trim = wr_fire && w_lane0_r && aw_addr_r == TRIM_OFS;
    assign wr_div = wr_fire && w_lane0_r && aw_addr_r == DIVCTL_OFS;
    assign aw_hit = aw_addr_r == TRIM_OFS || aw_addr_r == DIVCTL_OFS
                    || aw_addr_r == STATUS_OFS;

    // Address and data are caught separately, in either order
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_byte_r <= 8'h00;
            w_lane0_r <= 1'b0;
        end else if (CE_I) begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= {S_AXI_AWADDR_I[3:2], 2'h0};
            end else if (wr_fire) begin
                aw_full_r <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_r <= 1'b1;
                w_byte_r <= S_AXI_WDATA_I[7:0];
                w_lane0_r <= S_AXI_WSTRB_I[0];
            end else if (wr_fire) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Ready drops while a half is held, so one write at a time
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end else if (CE_I) begin
            S_AXI_AWREADY_O <= !aw_full_r && !S_AXI_BVALID_O
                               && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O);
            S_AXI_WREADY_O <= !w_full_r && !S_AXI_BVALID_O
                              && !(S_AXI_WVALID_I && S_AXI_WREADY_O);
            if (wr_fire) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= aw_hit ? RESP_OKAY : RESP_DECERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Trim register
    // ------------------------------------------------------------
    logic [7:0] trim_r;

    // Factory byte reloads on every chip reset; software may retune
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            trim_r <= TRIM_RST;
        end else if (CE_I) begin
            if (load_def) begin
                trim_r <= fuse_trim;
            end else if (wr_trim) begin
                trim_r <= w_byte_r;
            end
        end
    end

    // Range bit and fine bits go to the oscillator as they stand
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TRIM_RANGE_SELECT_O <= 1'b0;
            TRIM_FINE_TUNE_O <= 7'h00;
        end else if (CE_I) begin
            TRIM_RANGE_SELECT_O <= trim_r[RANGE_BIT];
            TRIM_FINE_TUNE_O <= trim_r[RANGE_BIT-1:0];
        end
    end

    // ------------------------------------------------------------
    // Divide control with timed unlock
    // ------------------------------------------------------------
    scp_unl_t unl_r;
    logic [2:0] unl_cnt_r;
    logic [3:0] div_sel_r;
    logic unl_req;
    logic sel_req;
    logic tick;

    // Unlock needs every other bit zero; a select write needs bit 7 low
    assign unl_req = wr_div && w_byte_r[UNLOCK_BIT]
                     && w_byte_r[UNLOCK_BIT-1:0] == 7'h00;
    assign sel_req = wr_div && !w_byte_r[UNLOCK_BIT];

    // Window counts system clock cycles, closed early by a select write
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            unl_r <= UNL_LOCKED;
            unl_cnt_r <= 3'h0;
        end else if (CE_I) begin
            case (unl_r)
                UNL_LOCKED: begin
                    if (unl_req && !load_def) begin
                        unl_r <= UNL_OPEN;
                        unl_cnt_r <= UNLOCK_TICKS;
                    end
                end
                UNL_OPEN: begin
                    // A repeated unlock write is simply not looked at
                    if (load_def || sel_req) begin
                        unl_r <= UNL_LOCKED;
                    end else if (tick) begin
                        if (unl_cnt_r == 3'h1) begin
                            unl_r <= UNL_LOCKED;
                        end
                        unl_cnt_r <= unl_cnt_r - 3'h1;
                    end
                end
                default: begin
                    unl_r <= UNL_LOCKED;
                end
            endcase
        end
    end

    // Select moves only on a default load or inside the window; any code is kept as written
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div_sel_r <= DIVSEL_DIV8;
        end else if (CE_I) begin
            if (load_def) begin
                div_sel_r <= fuse_div8 ? DIVSEL_DIV8 : DIVSEL_DIV1;
            end else if (sel_req && unl_r == UNL_OPEN) begin
                div_sel_r <= w_byte_r[DIVSEL_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    logic [7:0] cnt_r;
    logic [3:0] eff_code_r;
    logic sys_clk_r;
    logic [7:0] cnt_nxt;
    logic [3:0] code_nxt;
    logic [7:0] fm1_nxt;
    logic sys_clk_nxt;

    // Counter runs on the undivided clock; software never sees it
    assign tick = cnt_r == fm1_of(eff_code_r);
    assign cnt_nxt = tick ? 8'h00 : cnt_r + 8'h01;
    // New code is taken only at a period boundary, so the old period
    // always completes and no shortened phase can appear
    assign code_nxt = tick ? div_sel_r : eff_code_r;
    assign fm1_nxt = fm1_of(code_nxt);
    // Factor one can only toggle from a flop, so the level runs at half
    assign sys_clk_nxt = (fm1_nxt == 8'h00) ? !sys_clk_r
                         : cnt_nxt <= (fm1_nxt >> 1);

    // Divider keeps running through chip reset to feed the pin
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cnt_r <= 8'h00;
            eff_code_r <= DIVSEL_DIV8;
            sys_clk_r <= 1'b0;
        end else if (CE_I) begin
            cnt_r <= cnt_nxt;
            eff_code_r <= code_nxt;
            sys_clk_r <= sys_clk_nxt;
        end
    end

    // One strobe per divided period clocks every synchronous domain
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SYS_CLK_EN_O <= 1'b0;
            SYS_CLK_O <= 1'b0;
        end else if (CE_I) begin
            SYS_CLK_EN_O <= tick;
            SYS_CLK_O <= sys_clk_nxt;
        end
    end

    // ------------------------------------------------------------
    // Clock output pin
    // ------------------------------------------------------------
    // Fuse overrides the port function; chip reset does not stop it
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CLOCK_OUT_PIN_O <= 1'b0;
            CLOCK_OUT_PIN_OE_N_O <= 1'b1;
        end else if (CE_I) begin
            if (fuse_clock_out_fuse) begin
                CLOCK_OUT_PIN_O <= sys_clk_nxt;
                CLOCK_OUT_PIN_OE_N_O <= 1'b0;
            end else begin
                CLOCK_OUT_PIN_O <= PORT_OUT_I;
                CLOCK_OUT_PIN_OE_N_O <= PORT_OE_N_I;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_hit;
    logic [3:0] ar_ofs;

    assign ar_ofs = {S_AXI_ARADDR_I[3:2], 2'h0};

    // Decode as an if chain; unknown words answer with a decode error
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (ar_ofs == TRIM_OFS) begin
            rd_val[7:0] = trim_r;
        end else if (ar_ofs == DIVCTL_OFS) begin
            rd_val[UNLOCK_BIT] = unl_r == UNL_OPEN;
            rd_val[RSVD_MSB:RSVD_LSB] = 3'h0;
            rd_val[DIVSEL_MSB:0] = div_sel_r;
        end else if (ar_ofs == STATUS_OFS) begin
            rd_val[DIVSEL_MSB:0] = eff_code_r;
            rd_val[STAT_UNLOCK_BIT] = unl_r == UNL_OPEN;
            rd_val[STAT_CLOCK_OUT_FUSE_BIT] = fuse_clock_out_fuse;
            rd_val[STAT_DIV8_BIT] = fuse_div8;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Address is taken only while no read answer is pending
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else if (CE_I) begin
            S_AXI_ARREADY_O <= !S_AXI_RVALID_O
                               && !(S_AXI_ARVALID_I && S_AXI_ARREADY_O);
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= rd_val;
                S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_DECERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

endmodule

//--- testbench/scp_prescaler_asserts.sv
// Concurrent checks on the prescaler register bus and clock-out pin
`timescale 1ns/10ps
module scp_prescaler_asserts
    import scp_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic CLOCK_OUT_FUSE_I,
    input wire logic PORT_OUT_I,
    input wire logic PORT_OE_N_I,
    input wire logic CLOCK_OUT_PIN_O,
    input wire logic CLOCK_OUT_PIN_OE_N_O,
    input wire logic TRIM_RANGE_SELECT_O,
    input wire logic [6:0] TRIM_FINE_TUNE_O
);
    // ------------------------------------------------------------
    // Handshake sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence

    // Answers come at fixed distances from the handshakes
    a_write_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID_O)
        else $error("write response late");
    a_read_answer: assert property (rd_taken |=> S_AXI_RVALID_O)
        else $error("read data late");
    a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped before accepted");
    a_ready_drop: assert property (rd_taken |=> !S_AXI_ARREADY_O)
        else $error("read ready did not fall");
    a_decode_error: assert property (
        (rd_taken and S_AXI_ARADDR_I[3:2] == 2'h3)
        |=> S_AXI_RRESP_O == RESP_DECERR)
        else $error("unmapped read not refused");
    // Read data must show zero reserved bits and agree with what drives the oscillator
    a_rsvd_zero: assert property (
        (rd_taken and S_AXI_ARADDR_I[3:2] == 2'h1)
        |=> S_AXI_RDATA_O[6:4] == 3'h0 && S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("divider control reserved bits not zero");
    a_trim_match: assert property (
        (rd_taken and S_AXI_ARADDR_I[3:2] == 2'h0) |=> S_AXI_RDATA_O[7:0]
        == {TRIM_RANGE_SELECT_O, TRIM_FINE_TUNE_O})
        else $error("trim readback differs from trim outputs");
    // Fuse sync latency is three edges, so four samples are just enough
    a_pin_fuse_drive: assert property (
        CLOCK_OUT_FUSE_I [*4] |-> !CLOCK_OUT_PIN_OE_N_O)
        else $error("clock pin not driven with fuse set");
    a_pin_port_pass: assert property (!CLOCK_OUT_FUSE_I [*4]
        |-> CLOCK_OUT_PIN_OE_N_O == $past(PORT_OE_N_I)
        && CLOCK_OUT_PIN_O == $past(PORT_OUT_I))
        else $error("port function not passed to pin");
endmodule

//--- testbench/tb_system_clock_prescaler_trim.sv
// Self-checking bench for the system clock prescaler and trim block
`timescale 1ns/10ps
module tb_system_clock_prescaler_trim;
    import scp_pkg::*;
    logic CORE_CLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic CE_I = 1'b1;
    logic [3:0] S_AXI_AWADDR_I = 4'h0;
    logic [3:0] S_AXI_ARADDR_I = 4'h0;
    logic [31:0] S_AXI_WDATA_I = 32'h0;
    logic [3:0] S_AXI_WSTRB_I = 4'hf;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
    logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
    logic S_AXI_RREADY_I = 1'b0;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
    logic S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic [31:0] S_AXI_RDATA_O;
    logic [7:0] FACTORY_TRIM_I = 8'h5a;
    logic DEFAULT_DIV8_FUSE_I = 1'b1, CLOCK_OUT_FUSE_I = 1'b0;
    logic CHIP_RESET_I = 1'b0, PORT_OUT_I = 1'b0, PORT_OE_N_I = 1'b1;
    logic SYS_CLK_EN_O, SYS_CLK_O, CLOCK_OUT_PIN_O, CLOCK_OUT_PIN_OE_N_O;
    logic TRIM_RANGE_SELECT_O, prev;
    logic [6:0] TRIM_FINE_TUNE_O;
    logic [31:0] rd_q;
    logic [7:0] tv [2] = '{8'h7f, 8'h80};
    int failures = 0;
    int n_compared = 0;
    int cnt, c;

    scp_prescaler #(.ADDR_W(4)) scp_prescaler_i (.CORE_CLK_I, .RSTN_I,
        .CE_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
        .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
        .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
        .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
        .S_AXI_RVALID_O, .S_AXI_RREADY_I, .FACTORY_TRIM_I,
        .DEFAULT_DIV8_FUSE_I, .CLOCK_OUT_FUSE_I, .CHIP_RESET_I, .PORT_OUT_I,
        .PORT_OE_N_I, .SYS_CLK_EN_O, .SYS_CLK_O, .CLOCK_OUT_PIN_O,
        .CLOCK_OUT_PIN_OE_N_O, .TRIM_RANGE_SELECT_O, .TRIM_FINE_TUNE_O);

    always #5 CORE_CLK_I = ~CORE_CLK_I;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        int i;
        @(posedge CORE_CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= {24'h0, d};
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge CORE_CLK_I);
            if (S_AXI_BVALID_O) break;
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
        end
        S_AXI_BREADY_I <= 1'b0;
        chk({S_AXI_BVALID_O, S_AXI_BRESP_O}, {1'b1, r});
    endtask

    // Read: ready raised only once data is seen, so data must stand
    task automatic rd(input logic [3:0] a, input logic [1:0] r);
        int i;
        @(posedge CORE_CLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge CORE_CLK_I);
            if (S_AXI_RREADY_I && S_AXI_RVALID_O) break;
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
            if (S_AXI_RVALID_O) S_AXI_RREADY_I <= 1'b1;
        end
        S_AXI_RREADY_I <= 1'b0;
        rd_q = S_AXI_RDATA_O;
        chk({S_AXI_RVALID_O, S_AXI_RRESP_O}, {1'b1, r});
    endtask

    // Skip two pulses so the old period is gone, then time one period;
    // the divided level must be high for half of it
    task automatic per(input int f);
        int i, n, hi;
        n = 0;
        hi = 0;
        cnt = 0;
        for (i = 0; i < 1200 && n < 3; i++) begin
            @(posedge CORE_CLK_I);
            if (n == 2) cnt++;
            if (n == 2 && SYS_CLK_O) hi++;
            if (SYS_CLK_EN_O) n++;
        end
        chk(cnt, f);
        if (f > 1) chk(hi, f / 2);
    endtask

    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge CORE_CLK_I);
        RSTN_I <= 1'b1;
        repeat (6) @(posedge CORE_CLK_I);
        rd(TRIM_OFS, RESP_OKAY);
        chk(rd_q, 32'h5a);
        rd(DIVCTL_OFS, RESP_OKAY);
        chk(rd_q, 32'h3);
        per(8);
        foreach (tv[k]) begin
            wr(TRIM_OFS, tv[k], RESP_OKAY);
            rd(TRIM_OFS, RESP_OKAY);
            chk(rd_q, {24'h0, tv[k]});
            chk({TRIM_RANGE_SELECT_O, TRIM_FINE_TUNE_O}, tv[k]);
        end
        // Locked select and malformed unlock are both ignored
        wr(DIVCTL_OFS, 8'h05, RESP_OKAY);
        wr(DIVCTL_OFS, 8'h81, RESP_OKAY);
        rd(STATUS_OFS, RESP_OKAY);
        chk(rd_q[STAT_UNLOCK_BIT], 1'b0);
        chk(rd_q[3:0], 4'h3);
        wr(DIVCTL_OFS, 8'h80, RESP_OKAY);
        rd(STATUS_OFS, RESP_OKAY);
        chk(rd_q[STAT_UNLOCK_BIT], 1'b1);
        wr(DIVCTL_OFS, 8'h08, RESP_OKAY);
        rd(STATUS_OFS, RESP_OKAY);
        chk(rd_q[STAT_UNLOCK_BIT], 1'b0);
        per(256);
        // Rewrite at about one slow period must not extend the window
        wr(DIVCTL_OFS, 8'h80, RESP_OKAY);
        repeat (300) @(posedge CORE_CLK_I);
        wr(DIVCTL_OFS, 8'h80, RESP_OKAY);
        rd(STATUS_OFS, RESP_OKAY);
        chk(rd_q[STAT_UNLOCK_BIT], 1'b1);
        repeat (780) @(posedge CORE_CLK_I);
        rd(STATUS_OFS, RESP_OKAY);
        chk(rd_q[STAT_UNLOCK_BIT], 1'b0);
        wr(DIVCTL_OFS, 8'h02, RESP_OKAY);
        rd(DIVCTL_OFS, RESP_OKAY);
        chk(rd_q, 32'h8);
        // Codes 9 down to 1, reserved code 9 included, descending to stay slow
        for (c = 9; c >= 1; c--) begin
            wr(DIVCTL_OFS, 8'h80, RESP_OKAY);
            wr(DIVCTL_OFS, 8'(c), RESP_OKAY);
            rd(DIVCTL_OFS, RESP_OKAY);
            chk(rd_q, c);
            per(c > 8 ? 256 : 1 << c);
        end
        wr(4'hc, 8'h11, RESP_DECERR);
        rd(4'hc, RESP_DECERR);
        // Pin follows the port, then the clock, also in chip reset
        PORT_OUT_I <= 1'b1;
        PORT_OE_N_I <= 1'b0;
        repeat (6) @(posedge CORE_CLK_I);
        chk({CLOCK_OUT_PIN_OE_N_O, CLOCK_OUT_PIN_O}, 2'b01);
        CLOCK_OUT_FUSE_I <= 1'b1;
        CHIP_RESET_I <= 1'b1;
        DEFAULT_DIV8_FUSE_I <= 1'b0;
        FACTORY_TRIM_I <= 8'h33;
        repeat (8) @(posedge CORE_CLK_I);
        cnt = 0;
        prev = CLOCK_OUT_PIN_O;
        repeat (64) begin
            @(posedge CORE_CLK_I);
            if (CLOCK_OUT_PIN_O && !prev) cnt++;
            prev = CLOCK_OUT_PIN_O;
        end
        chk(cnt, 32);
        chk(CLOCK_OUT_PIN_OE_N_O, 1'b0);
        CHIP_RESET_I <= 1'b0;
        repeat (6) @(posedge CORE_CLK_I);
        rd(TRIM_OFS, RESP_OKAY);
        chk(rd_q, 32'h33);
        rd(DIVCTL_OFS, RESP_OKAY);
        chk(rd_q, 32'h0);
        per(1);
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge CORE_CLK_I);
        failures++;
        wrap_up();
    end
endmodule

bind scp_prescaler scp_prescaler_asserts #(.ADDR_W(ADDR_W))
    scp_prescaler_asserts_i (.CORE_CLK_I, .RSTN_I, .S_AXI_AWVALID_I,
    .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O,
    .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
    .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .CLOCK_OUT_FUSE_I,
    .PORT_OUT_I, .PORT_OE_N_I, .CLOCK_OUT_PIN_O, .CLOCK_OUT_PIN_OE_N_O,
    .TRIM_RANGE_SELECT_O, .TRIM_FINE_TUNE_O);
